// >>> adsi_top.sv
// Purpose: Per-axis drive feedback inputs and inhibit outputs
// Assumes: AXI4-Lite slave, 25 MHz clk, inputs synchronous to clk
// Notes: Local design decisions are noted below
//
// The address map and the AXI4-Lite register port were decided locally.
`timescale 1ns/10ps
`default_nettype none
module adsi_top
    import adsi_pkg::*;
#(
    parameter int NAXES = ADSI_NAXES
) (
    // Clock, reset, enable
    input wire logic clk,
    input wire logic rst,
    input wire logic ce,
    // AXI4-Lite write address
    input wire logic [7:0] s_axi_awaddr,
    input wire logic s_axi_awvalid,
    output logic s_axi_awready,
    // AXI4-Lite write data
    input wire logic [31:0] s_axi_wdata,
    input wire logic [3:0] s_axi_wstrb,
    input wire logic s_axi_wvalid,
    output logic s_axi_wready,
    // AXI4-Lite write response
    output logic [1:0] s_axi_bresp,
    output logic s_axi_bvalid,
    input wire logic s_axi_bready,
    // AXI4-Lite read address
    input wire logic [7:0] s_axi_araddr,
    input wire logic s_axi_arvalid,
    output logic s_axi_arready,
    // AXI4-Lite read data
    output logic [31:0] s_axi_rdata,
    output logic [1:0] s_axi_rresp,
    output logic s_axi_rvalid,
    input wire logic s_axi_rready,
    // Drive side inputs
    input wire logic [ADSI_NPORTS*ADSI_PORT_BITS-1:0] gpio_in,
    input wire logic [ADSI_PORT_BITS-1:0] high_speed_capture_port,
    // Trajectory side
    input wire logic [NAXES-1:0] traj_done,
    // Outputs
    output logic [NAXES-1:0] inhibit_pin,
    output logic [NAXES-1:0] move_complete,
    output logic [NAXES-1:0] loop_enable,
    output logic [NAXES-1:0] dac_zero,
    output logic irq
);
    // Axis count must fit the three-bit axis index
    if (NAXES < 1 || NAXES > ADSI_NAXES) begin : g_bad_naxes
        $error("NAXES out of range");
    end

    // Configuration and state
    logic [NAXES-1:0] inhibit_en;
    logic [NAXES-1:0] inhibit_pol;
    logic [NAXES-1:0] inhibit_direct_value;
    logic [NAXES-1:0] killed;
    logic [NAXES-1:0] irq_status;
    logic [NAXES-1:0] irq_enable;
    logic [8:0] inpos_cfg [NAXES];
    logic [8:0] fault_cfg [NAXES];
    logic [NAXES-1:0] inpos_act;
    logic [NAXES-1:0] fault_act;
    logic [NAXES-1:0] kill_sw;
    logic [NAXES-1:0] fault_q;

    // Write channel holding
    logic aw_held;
    logic w_held;
    logic [7:0] aw_addr;
    logic [31:0] w_data;
    logic [3:0] w_strb;
    logic do_write;
    logic [4:0] w_idx;
    assign do_write = aw_held && w_held && !s_axi_bvalid;
    assign w_idx = aw_addr[6:2];

    // Address and data capture
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            aw_held <= 1'b0;
            w_held <= 1'b0;
            aw_addr <= 8'h00;
            w_data <= ADSI_RESET_ZERO;
            w_strb <= 4'h0;
            s_axi_awready <= 1'b0;
            s_axi_wready <= 1'b0;
        end else if (ce) begin
            s_axi_awready <= 1'b0;
            s_axi_wready <= 1'b0;
            if (s_axi_awvalid && !aw_held && !s_axi_awready) begin
                aw_held <= 1'b1;
                aw_addr <= s_axi_awaddr;
                s_axi_awready <= 1'b1;
            end else if (do_write) begin
                aw_held <= 1'b0;
            end
            if (s_axi_wvalid && !w_held && !s_axi_wready) begin
                w_held <= 1'b1;
                w_data <= s_axi_wdata;
                w_strb <= s_axi_wstrb;
                s_axi_wready <= 1'b1;
            end else if (do_write) begin
                w_held <= 1'b0;
            end
        end
    end

    // Write response
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            s_axi_bvalid <= 1'b0;
            s_axi_bresp <= ADSI_RESP_OKAY;
        end else if (ce) begin
            if (do_write) begin
                s_axi_bvalid <= 1'b1;
                s_axi_bresp <= (aw_addr >= ADSI_REG_INPOS_BASE && w_idx[2:0] >= NAXES) ||
                               aw_addr[7] ? ADSI_RESP_SLVERR : ADSI_RESP_OKAY;
            end else if (s_axi_bready) begin
                s_axi_bvalid <= 1'b0;
            end
        end
    end

    // Configuration registers, low byte lane holds port and bit fields, byte lane 1 the enable bit
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            inhibit_en <= '0;
            inhibit_pol <= '0;
            inhibit_direct_value <= '0;
            irq_enable <= '0;
            for (int i = 0; i < NAXES; i++) begin
                inpos_cfg[i] <= 9'h000;
                fault_cfg[i] <= 9'h000;
            end
        end else if (ce && do_write) begin
            if (w_strb[0]) begin
                unique case (aw_addr)
                    ADSI_REG_INHIBIT_EN: inhibit_en <= w_data[NAXES-1:0];
                    ADSI_REG_INHIBIT_POL: inhibit_pol <= w_data[NAXES-1:0];
                    ADSI_REG_INHIBIT_DIRECT: inhibit_direct_value <= w_data[NAXES-1:0];
                    ADSI_REG_IRQ_ENABLE: irq_enable <= w_data[NAXES-1:0];
                    default: begin
                        if (aw_addr[7:5] == ADSI_REG_INPOS_BASE[7:5] && w_idx[2:0] < NAXES) begin
                            inpos_cfg[w_idx[2:0]][7:0] <= w_data[7:0];
                        end
                        if (aw_addr[7:5] == ADSI_REG_FAULT_BASE[7:5] && w_idx[2:0] < NAXES) begin
                            fault_cfg[w_idx[2:0]][7:0] <= w_data[7:0];
                        end
                    end
                endcase
            end
            if (w_strb[1]) begin
                if (aw_addr[7:5] == ADSI_REG_INPOS_BASE[7:5] && w_idx[2:0] < NAXES) begin
                    inpos_cfg[w_idx[2:0]][ADSI_CFG_EN_BIT] <= w_data[ADSI_CFG_EN_BIT];
                end
                if (aw_addr[7:5] == ADSI_REG_FAULT_BASE[7:5] && w_idx[2:0] < NAXES) begin
                    fault_cfg[w_idx[2:0]][ADSI_CFG_EN_BIT] <= w_data[ADSI_CFG_EN_BIT];
                end
            end
        end
    end

    // Software kill and revive strobes
    always_comb begin
        kill_sw = '0;
        if (do_write && w_strb[0] && aw_addr == ADSI_REG_KILL_SET) begin
            kill_sw = w_data[NAXES-1:0];
        end
    end

    // Per-axis line selectors
    genvar g;
    generate
        for (g = 0; g < NAXES; g++) begin : g_axis
            adsi_sel_if ip_if();
            adsi_sel_if ft_if();
            assign ip_if.port_sel = inpos_cfg[g][ADSI_CFG_PORT_LSB +: 4];
            assign ip_if.bit_sel = inpos_cfg[g][ADSI_CFG_BIT_LSB +: 3];
            assign ip_if.enabled = inpos_cfg[g][ADSI_CFG_EN_BIT];
            assign ft_if.port_sel = fault_cfg[g][ADSI_CFG_PORT_LSB +: 4];
            assign ft_if.bit_sel = fault_cfg[g][ADSI_CFG_BIT_LSB +: 3];
            assign ft_if.enabled = fault_cfg[g][ADSI_CFG_EN_BIT];
            adsi_line_sel u_ip (
                .gpio_in(gpio_in),
                .high_speed_capture_port(high_speed_capture_port),
                .s(ip_if.sel)
            );
            adsi_line_sel u_ft (
                .gpio_in(gpio_in),
                .high_speed_capture_port(high_speed_capture_port),
                .s(ft_if.sel)
            );
            assign inpos_act[g] = ip_if.active;
            assign fault_act[g] = ft_if.active;
            // Per-axis fault kill and capture mapping checks
            AST_FAULT_KILLS: assert property (@(posedge clk) disable iff (rst)
                ce && fault_act[g] |=> killed[g]) else $error("fault did not kill axis");
            AST_CAPTURE_MAP: assert property (@(posedge clk) disable iff (rst)
                fault_cfg[g][ADSI_CFG_EN_BIT] && fault_cfg[g][ADSI_CFG_PORT_LSB +: 4] == ADSI_PORT_CAPTURE
                |-> fault_act[g] == high_speed_capture_port[fault_cfg[g][ADSI_CFG_BIT_LSB +: 3]])
                else $error("capture port mapping wrong");
        end
    endgenerate

    // Axis kill state: fault kills, software write 1 kills, 0 revives
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            killed <= '0;
            fault_q <= '0;
        end else if (ce) begin
            fault_q <= fault_act;
            if (do_write && w_strb[0] && aw_addr == ADSI_REG_KILL_SET) begin
                killed <= kill_sw | fault_act;
            end else begin
                killed <= killed | fault_act;
            end
        end
    end

    // Kill consequences, immediate with no ramp
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            loop_enable <= '0;
            dac_zero <= '1;
        end else if (ce) begin
            loop_enable <= ~killed;
            dac_zero <= killed;
        end
    end

    // Move complete gated by in-position
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            move_complete <= '0;
        end else if (ce) begin
            for (int i = 0; i < NAXES; i++) begin
                move_complete[i] <= traj_done[i] && (!inpos_cfg[i][ADSI_CFG_EN_BIT] || inpos_act[i]);
            end
        end
    end

    // Inhibit pins: linked or direct, then polarity (pol=1 active high)
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            inhibit_pin <= '0;
        end else if (ce) begin
            for (int i = 0; i < NAXES; i++) begin
                inhibit_pin[i] <= (inhibit_en[i] ? killed[i] : inhibit_direct_value[i])
                                  ~^ inhibit_pol[i];
            end
        end
    end

    // Sticky fault events, set wins over clear
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            irq_status <= '0;
            irq <= 1'b0;
        end else if (ce) begin
            if (do_write && w_strb[0] && aw_addr == ADSI_REG_IRQ_CLEAR) begin
                irq_status <= (irq_status & ~w_data[NAXES-1:0]) | (fault_act & ~fault_q);
            end else begin
                irq_status <= irq_status | (fault_act & ~fault_q);
            end
            irq <= |(irq_status & irq_enable);
        end
    end

    // Read channel
    logic [31:0] rd_word;
    logic rd_bad;
    logic [4:0] r_idx;
    assign r_idx = s_axi_araddr[6:2];
    always_comb begin
        rd_word = ADSI_RESET_ZERO;
        rd_bad = 1'b0;
        unique case (s_axi_araddr)
            ADSI_REG_INHIBIT_EN: rd_word[NAXES-1:0] = inhibit_en;
            ADSI_REG_INHIBIT_POL: rd_word[NAXES-1:0] = inhibit_pol;
            ADSI_REG_INHIBIT_DIRECT: rd_word[NAXES-1:0] = inhibit_direct_value;
            ADSI_REG_KILL_SET: rd_word[NAXES-1:0] = killed;
            ADSI_REG_AXIS_STATE: rd_word = {16'h0000, 8'(move_complete), 8'(killed)};
            ADSI_REG_IRQ_STATUS: rd_word[NAXES-1:0] = irq_status;
            ADSI_REG_IRQ_CLEAR: rd_word = ADSI_RESET_ZERO;
            ADSI_REG_IRQ_ENABLE: rd_word[NAXES-1:0] = irq_enable;
            default: begin
                if (s_axi_araddr[7:5] == ADSI_REG_INPOS_BASE[7:5] && r_idx[2:0] < NAXES) begin
                    rd_word[8:0] = inpos_cfg[r_idx[2:0]];
                    rd_word[16] = inpos_act[r_idx[2:0]];
                end else if (s_axi_araddr[7:5] == ADSI_REG_FAULT_BASE[7:5] && r_idx[2:0] < NAXES) begin
                    rd_word[8:0] = fault_cfg[r_idx[2:0]];
                    rd_word[16] = fault_act[r_idx[2:0]];
                end else begin
                    rd_bad = 1'b1;
                end
            end
        endcase
    end

    // Read response register
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            s_axi_arready <= 1'b0;
            s_axi_rvalid <= 1'b0;
            s_axi_rdata <= ADSI_RESET_ZERO;
            s_axi_rresp <= ADSI_RESP_OKAY;
        end else if (ce) begin
            s_axi_arready <= 1'b0;
            if (s_axi_arvalid && !s_axi_rvalid && !s_axi_arready) begin
                s_axi_arready <= 1'b1;
                s_axi_rvalid <= 1'b1;
                s_axi_rdata <= rd_word;
                s_axi_rresp <= rd_bad ? ADSI_RESP_SLVERR : ADSI_RESP_OKAY;
            end else if (s_axi_rready && s_axi_rvalid) begin
                s_axi_rvalid <= 1'b0;
            end
        end
    end

    // Checks
    AST_KILL_LOOP: assert property (@(posedge clk) disable iff (rst)
        ce && killed[0] |=> !loop_enable[0] && dac_zero[0]) else $error("kill left loop on");
    AST_INH_ON: assert property (@(posedge clk) disable iff (rst)
        ce && inhibit_en[0] && killed[0] |=> inhibit_pin[0] == $past(inhibit_pol[0]))
        else $error("inhibit not on for killed axis");
    AST_INH_OFF: assert property (@(posedge clk) disable iff (rst)
        ce && inhibit_en[0] && !killed[0] |=> inhibit_pin[0] != $past(inhibit_pol[0]))
        else $error("inhibit not off for active axis");
    AST_INH_DIRECT: assert property (@(posedge clk) disable iff (rst)
        ce && !inhibit_en[1] |=> inhibit_pin[1] == ($past(inhibit_direct_value[1]) ~^ $past(inhibit_pol[1])))
        else $error("direct inhibit wrong");
    AST_POLARITY: assert property (@(posedge clk) disable iff (rst)
        ce && $stable(inhibit_en) && $stable(killed) && $stable(inhibit_direct_value) && $changed(inhibit_pol)
        |=> inhibit_pin != $past(inhibit_pin)) else $error("polarity change ignored");
    AST_INPOS_GATE: assert property (@(posedge clk) disable iff (rst)
        ce && inpos_cfg[0][ADSI_CFG_EN_BIT] && !inpos_act[0] |=> !move_complete[0])
        else $error("move complete without in-position");
    AST_RESET_STATE: assert property (@(posedge clk)
        $fell(rst) |-> inhibit_en == '0 && inhibit_direct_value == '0 && !inpos_cfg[0][ADSI_CFG_EN_BIT])
        else $error("reset state wrong");
endmodule : adsi_top
`default_nettype wire

// >>> adsi_pkg.sv
// Purpose: Shared constants for the axis drive signal and inhibit I/O block
// Assumes: 32-bit AXI4-Lite register bus, eight axes
// Notes: Offsets are byte addresses
`default_nettype none
package adsi_pkg;
    localparam int ADSI_NAXES = 8;
    localparam int ADSI_PORT_BITS = 8;
    localparam int ADSI_NPORTS = 8;
    // Port selector codes
    localparam logic [3:0] ADSI_PORT_FIRST = 4'h1;
    localparam logic [3:0] ADSI_PORT_LAST = 4'h8;
    localparam logic [3:0] ADSI_PORT_CAPTURE = 4'ha;
    // Register offsets
    localparam logic [7:0] ADSI_REG_INHIBIT_EN = 8'h00;
    localparam logic [7:0] ADSI_REG_INHIBIT_POL = 8'h04;
    localparam logic [7:0] ADSI_REG_INHIBIT_DIRECT = 8'h08;
    localparam logic [7:0] ADSI_REG_KILL_SET = 8'h0c;
    localparam logic [7:0] ADSI_REG_AXIS_STATE = 8'h10;
    localparam logic [7:0] ADSI_REG_IRQ_STATUS = 8'h14;
    localparam logic [7:0] ADSI_REG_IRQ_CLEAR = 8'h18;
    localparam logic [7:0] ADSI_REG_IRQ_ENABLE = 8'h1c;
    localparam logic [7:0] ADSI_REG_INPOS_BASE = 8'h20;
    localparam logic [7:0] ADSI_REG_FAULT_BASE = 8'h40;
    // Drive signal config word fields
    localparam int ADSI_CFG_BIT_LSB = 0;
    localparam int ADSI_CFG_PORT_LSB = 4;
    localparam int ADSI_CFG_EN_BIT = 8;
    localparam logic [31:0] ADSI_RESET_ZERO = 32'h0000_0000;
    localparam logic [1:0] ADSI_RESP_OKAY = 2'h0;
    localparam logic [1:0] ADSI_RESP_SLVERR = 2'h2;
endpackage : adsi_pkg
`default_nettype wire

// >>> adsi_sel_if.sv
// Purpose: Carries one drive signal selection between top and selector
// Assumes: Single clock domain
// Notes: Selector is purely combinational
`timescale 1ns/10ps
`default_nettype none
interface adsi_sel_if;
    logic [3:0] port_sel;
    logic [2:0] bit_sel;
    logic enabled;
    logic line;
    logic active;
    modport ctrl (output port_sel, output bit_sel, output enabled, input active);
    modport sel (input port_sel, input bit_sel, input enabled, output line, output active);
endinterface : adsi_sel_if
`default_nettype wire

// >>> adsi_line_sel.sv
// Purpose: Picks one reserved drive feedback line from the I/O ports
// Assumes: Inputs synchronous to clk, already in active-high sense
// Notes: Illegal selectors yield an inactive line
`timescale 1ns/10ps
`default_nettype none
module adsi_line_sel
    import adsi_pkg::*;
(
    // Port inputs
    input wire logic [ADSI_NPORTS*ADSI_PORT_BITS-1:0] gpio_in,
    input wire logic [ADSI_PORT_BITS-1:0] high_speed_capture_port,
    // Selection
    adsi_sel_if.sel s
);
    logic [ADSI_PORT_BITS-1:0] port_word;
    logic [3:0] gp_index;
    // Port word by selector
    always_comb begin
        port_word = '0;
        gp_index = s.port_sel - ADSI_PORT_FIRST;
        if (s.port_sel >= ADSI_PORT_FIRST && s.port_sel <= ADSI_PORT_LAST) begin
            port_word = gpio_in[gp_index[2:0]*ADSI_PORT_BITS +: ADSI_PORT_BITS];
        end else if (s.port_sel == ADSI_PORT_CAPTURE) begin
            port_word = high_speed_capture_port;
        end
    end
    // Bit pick and gating
    assign s.line = port_word[s.bit_sel];
    assign s.active = s.enabled & s.line;
endmodule : adsi_line_sel
`default_nettype wire

// >>> adsi_drive_model.sv
// Purpose: Behavioural amplifier or stepper drive feeding back in-position and fault
// Assumes: Bench commands target reached and alarm through two inputs
// Notes: SETTLE sets how slowly in-position follows the target
`timescale 1ns/10ps
`default_nettype none
module adsi_drive_model #(
    parameter int SETTLE = 3
) (
    // Clock and reset
    input wire logic clk,
    input wire logic rst,
    // Commands from the bench
    input wire logic at_target,
    input wire logic fault_req,
    // Drive feedback lines
    output logic in_pos,
    output logic fault
);
    int cnt;
    // In-position only once the motor has settled at target
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            cnt <= 0;
            in_pos <= 1'b0;
        end else if (!at_target) begin
            cnt <= 0;
            in_pos <= 1'b0;
        end else if (cnt < SETTLE) begin
            cnt <= cnt + 1;
        end else begin
            in_pos <= 1'b1;
        end
    end
    // Alarm line follows the commanded fault
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            fault <= 1'b0;
        end else begin
            fault <= fault_req;
        end
    end
endmodule : adsi_drive_model
`default_nettype wire

// >>> adsi_testbench.sv
// Purpose: Register-driven checks of drive feedback and inhibit outputs
// Assumes: Bus tasks wait for each answer, only the watchdog ends a wait
// Notes: Fault sits on port 3 bit 5, in-position on port 1 bit 0
`timescale 1ns/10ps
`default_nettype none
module testbench;
    import adsi_pkg::*;
    logic clk = 1'b0;
    logic rst = 1'b1;
    logic [7:0] awaddr = 8'h00;
    logic [7:0] araddr = 8'h00;
    logic [31:0] wdata = 32'h0;
    logic awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0, arvalid = 1'b0, rready = 1'b0;
    logic [63:0] gpio_base = 64'h0;
    logic [7:0] cap = 8'h00;
    logic [7:0] traj_done = 8'h00;
    logic at_target = 1'b0, fault_req = 1'b0, in_pos, fault;
    logic [63:0] gpio_in;
    logic awready, wready, bvalid, arready, rvalid, irq;
    logic [1:0] bresp, rresp, rr;
    logic [31:0] rdata, rd;
    logic [7:0] inhibit_pin, move_complete, loop_enable, dac_zero;
    int mismatches = 0;
    int comparisons = 0;

    // Clock and drive lines onto the I/O ports
    always #20 clk = ~clk;
    assign gpio_in = gpio_base | {42'h0, fault, 20'h0, in_pos};

    adsi_top dut (.clk(clk), .rst(rst), .ce(1'b1),
        .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid), .s_axi_awready(awready),
        .s_axi_wdata(wdata), .s_axi_wstrb(4'hf), .s_axi_wvalid(wvalid), .s_axi_wready(wready),
        .s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready),
        .s_axi_araddr(araddr), .s_axi_arvalid(arvalid), .s_axi_arready(arready),
        .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(rready),
        .gpio_in(gpio_in), .high_speed_capture_port(cap), .traj_done(traj_done),
        .inhibit_pin(inhibit_pin), .move_complete(move_complete), .loop_enable(loop_enable),
        .dac_zero(dac_zero), .irq(irq));

    adsi_drive_model #(.SETTLE(3)) drive (.clk(clk), .rst(rst), .at_target(at_target),
        .fault_req(fault_req), .in_pos(in_pos), .fault(fault));

    // Compare and count
    task automatic check(input string name, input logic [31:0] seen, input logic [31:0] exp);
        comparisons++;
        if (seen !== exp) begin
            mismatches++;
            $display("mismatch %s expected %h seen %h", name, exp, seen);
        end
    endtask : check

    // Bus write, both channels offered together
    task automatic axi_write(input logic [7:0] a, input logic [31:0] d);
        logic done = 1'b0;
        @(posedge clk);
        awaddr <= a;
        wdata <= d;
        awvalid <= 1'b1;
        wvalid <= 1'b1;
        bready <= 1'b1;
        while (!done) begin
            @(posedge clk);
            if (awready === 1'b1) awvalid <= 1'b0;
            if (wready === 1'b1) wvalid <= 1'b0;
            if (bvalid === 1'b1) begin
                check("bresp", {30'h0, bresp}, {30'h0, ADSI_RESP_OKAY});
                bready <= 1'b0;
                done = 1'b1;
            end
        end
    endtask : axi_write

    // Bus read
    task automatic axi_read(input logic [7:0] a, output logic [31:0] d, output logic [1:0] r);
        logic done = 1'b0;
        d = 32'h0;
        r = 2'h3;
        @(posedge clk);
        araddr <= a;
        arvalid <= 1'b1;
        rready <= 1'b1;
        while (!done) begin
            @(posedge clk);
            if (arready === 1'b1) arvalid <= 1'b0;
            if (rvalid === 1'b1) begin
                d = rdata;
                r = rresp;
                rready <= 1'b0;
                done = 1'b1;
            end
        end
    endtask : axi_read

    task automatic read_check(input string name, input logic [7:0] a, input logic [31:0] exp);
        axi_read(a, rd, rr);
        check(name, rd, exp);
    endtask : read_check

    // Let registered outputs settle
    task automatic settle();
        repeat (4) @(posedge clk);
        #1;
    endtask : settle

    task automatic end_sim();
        $display("mismatches %0d comparisons %0d", mismatches, comparisons);
        if (mismatches == 0 && comparisons > 0) $display("SIMULATION PASSED");
        else $display("SIMULATION FAILED");
        $finish;
    endtask : end_sim

    // Watchdog
    initial begin
        repeat (20000) @(posedge clk);
        mismatches++;
        end_sim();
    end

    // Main sequence
    initial begin
        repeat (2) @(posedge clk);
        rst <= 1'b0;
        traj_done <= 8'hff;
        settle();
        check("inhibit_pin", {24'h0, inhibit_pin}, 32'hff);
        read_check("inh_en", ADSI_REG_INHIBIT_EN, 32'h0);
        read_check("direct", ADSI_REG_INHIBIT_DIRECT, 32'h0);
        read_check("inpos_cfg", ADSI_REG_INPOS_BASE, 32'h0);
        read_check("fault_cfg", ADSI_REG_FAULT_BASE + 8'h1c, 32'h0);
        // Direct value, active low then active high
        axi_write(ADSI_REG_INHIBIT_DIRECT, 32'h05);
        settle();
        check("inhibit_pin", {24'h0, inhibit_pin}, 32'hfa);
        axi_write(ADSI_REG_INHIBIT_POL, 32'hff);
        settle();
        check("inhibit_pin", {24'h0, inhibit_pin}, 32'h05);
        // Linked outputs follow kill state, upper axes stay direct
        axi_write(ADSI_REG_INHIBIT_EN, 32'h0f);
        axi_write(ADSI_REG_KILL_SET, 32'h03);
        settle();
        check("inhibit_pin", {24'h0, inhibit_pin}, 32'h03);
        check("loop_enable", {24'h0, loop_enable}, 32'hfc);
        check("dac_zero", {24'h0, dac_zero}, 32'h03);
        read_check("killed", ADSI_REG_KILL_SET, 32'h03);
        axi_write(ADSI_REG_INHIBIT_POL, 32'h00);
        settle();
        check("inhibit_pin", {24'h0, inhibit_pin}, 32'hfc);
        axi_write(ADSI_REG_KILL_SET, 32'h00);
        settle();
        check("inhibit_pin", {24'h0, inhibit_pin}, 32'hff);
        // Drive fault on port 3 bit 5 kills axis 2 and flags it
        axi_write(ADSI_REG_FAULT_BASE + 8'h08, 32'h135);
        @(posedge clk);
        fault_req <= 1'b1;
        settle();
        check("loop_enable", {24'h0, loop_enable}, 32'hfb);
        check("dac_zero", {24'h0, dac_zero}, 32'h04);
        read_check("irq_status", ADSI_REG_IRQ_STATUS, 32'h04);
        check("irq_masked", {31'h0, irq}, 32'h0);
        axi_write(ADSI_REG_IRQ_ENABLE, 32'h04);
        settle();
        check("irq", {31'h0, irq}, 32'h1);
        @(posedge clk);
        fault_req <= 1'b0;
        axi_write(ADSI_REG_IRQ_CLEAR, 32'h04);
        settle();
        check("irq_cleared", {31'h0, irq}, 32'h0);
        read_check("irq_status", ADSI_REG_IRQ_STATUS, 32'h00);
        axi_write(ADSI_REG_KILL_SET, 32'h00);
        // Capture trigger 7 kills axis 3
        axi_write(ADSI_REG_FAULT_BASE + 8'h0c, 32'h1a7);
        @(posedge clk);
        cap <= 8'h80;
        settle();
        read_check("state", ADSI_REG_AXIS_STATE, 32'hff08);
        read_check("line_active", ADSI_REG_FAULT_BASE + 8'h0c, 32'h1_01a7);
        @(posedge clk);
        cap <= 8'h00;
        axi_write(ADSI_REG_KILL_SET, 32'h00);
        // In-position on port 1 bit 0 gates axis 0 move complete
        axi_write(ADSI_REG_INPOS_BASE, 32'h110);
        settle();
        check("move_complete", {24'h0, move_complete}, 32'hfe);
        @(posedge clk);
        at_target <= 1'b1;
        settle();
        settle();
        check("move_complete", {24'h0, move_complete}, 32'hff);
        // Port 8 is legal, port 9 yields an inactive line
        axi_write(ADSI_REG_FAULT_BASE + 8'h14, 32'h187);
        axi_write(ADSI_REG_FAULT_BASE + 8'h10, 32'h190);
        @(posedge clk);
        gpio_base <= 64'hffff_ffff_ffff_ffff;
        settle();
        axi_read(ADSI_REG_AXIS_STATE, rd, rr);
        check("killed_5_4", {30'h0, rd[5:4]}, 32'h2);
        // Unmapped offset
        axi_read(8'hfc, rd, rr);
        check("rresp", {30'h0, rr}, {30'h0, ADSI_RESP_SLVERR});
        end_sim();
    end
endmodule : testbench
`default_nettype wire
